// [hw/uefc_pkg.sv]
`default_nettype none
package uefc_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [3:0] OFS_IER  = 4'h1;
  localparam logic [3:0] OFS_EFR  = 4'h2;  // Also fifo_control write / interrupt_ident read
  localparam logic [3:0] OFS_LCR  = 4'h3;
  localparam logic [3:0] OFS_MCR  = 4'h4;  // Shared with resume_char_one when unlocked
  localparam logic [3:0] OFS_RES1 = 4'h4;
  localparam logic [3:0] OFS_RES2 = 4'h5;
  localparam logic [3:0] OFS_PAU1 = 4'h6;
  localparam logic [3:0] OFS_PAU2 = 4'h7;
  localparam logic [3:0] OFS_TCR  = 4'h6;
  localparam logic [3:0] OFS_TLP  = 4'h7;
  localparam logic [3:0] OFS_SFR  = 4'h8;
  // ----------------------------------------
  // Reset values and keys
  // ----------------------------------------
  localparam logic [7:0] LCR_UNLOCK = 8'hbf;
  localparam logic [7:0] LCR_RST    = 8'h1d;
  localparam logic [7:0] REG_RST    = 8'h00;
  // ----------------------------------------
  // Field positions and masks
  // ----------------------------------------
  localparam int EFR_AUTO_CTS = 7;
  localparam int EFR_AUTO_RTS = 6;
  localparam int EFR_SPEC_DET = 5;
  localparam int EFR_ENH      = 4;
  localparam int SFR_LOCK     = 2;
  localparam int IIR_SPECIAL  = 4;
  localparam int IIR_PAUSE    = 5;
  localparam int MCR_RTS      = 1;
  localparam int IER_SLEEP    = 4;
  localparam logic [7:0] IER_ENH_MASK = 8'hf0;
  localparam logic [7:0] FCR_ENH_MASK = 8'h30;
  localparam logic [7:0] MCR_ENH_MASK = 8'he0;
  // Flow control select halves
  localparam logic [1:0] FC_NONE = 2'h0;
  localparam logic [1:0] FC_ONE  = 2'h2;
  localparam logic [1:0] FC_TWO  = 2'h1;
  localparam logic [1:0] FC_BOTH = 2'h3;
  // Character slots (hit vector order)
  localparam int CH_RES1 = 0;
  localparam int CH_RES2 = 1;
  localparam int CH_PAU1 = 2;
  localparam int CH_PAU2 = 3;
  localparam int CH_NUM  = 4;
  // Transmit flow character sender
  typedef enum logic [1:0] {
    TX_IDLE   = 2'h0,
    TX_FIRST  = 2'h1,
    TX_SECOND = 2'h3
  } uefc_txst_t;
endpackage
`default_nettype wire

// [hw/uefc_match_if.sv]
`default_nettype none
// Character compare bundle between the core and the matcher
interface uefc_match_if #(parameter int W = 8);
  logic [W-1:0] rx_data;
  logic [W-1:0] chars [uefc_pkg::CH_NUM];
  logic [uefc_pkg::CH_NUM-1:0] hits;
  modport cmp (input rx_data, input chars, output hits);
  modport use_side (output rx_data, output chars, input hits);
endinterface
`default_nettype wire

// [hw/uefc_match.sv]
`default_nettype none
// ----------------------------------------
// Flow character matcher
// ----------------------------------------
module uefc_match #(parameter int W = 8) (
  uefc_match_if.cmp m
);
  // One comparator per programmed character
  for (genvar i = 0; i < uefc_pkg::CH_NUM; i++) begin : g_cmp
    assign m.hits[i] = (m.rx_data == m.chars[i]);
  end
endmodule
`default_nettype wire

// [hw/uefc_top.sv]
`default_nettype none
module uefc_top #(parameter int W = 8) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  // Host register port
  input  wire logic [3:0]   reg_addr,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  input  wire logic [7:0]   reg_wdata,
  output logic      [7:0]   reg_rdata,
  // Received characters from the receiver
  input  wire logic         rx_valid,
  input  wire logic [W-1:0] rx_data,
  output logic              fifo_wr,
  output logic      [W-1:0] fifo_data,
  input  wire logic         rx_level_high,
  // Flow characters toward the transmitter
  output logic              fc_valid,
  output logic      [W-1:0] fc_data,
  input  wire logic         fc_ready,
  // Modem pins and status
  input  wire logic         cts_n,
  output logic              rts_n,
  output logic              cts_stop,
  output logic              tx_hold,
  output logic              special_flag,
  output logic              pause_flag,
  output logic              sleep_ok
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [7:0] line_control, supplementary_feature, enhanced_feature_control, interrupt_enable_reg, fifo_control, modem_control, transmission_control, trigger_level_reg;
  logic [7:0] next_lcr, next_sfr, next_efr, next_ier, next_fcr, next_mcr, next_tcr, next_tlp;
  logic [W-1:0] chars [uefc_pkg::CH_NUM];
  logic [W-1:0] next_chars [uefc_pkg::CH_NUM];
  logic [7:0] next_reg_rdata;
  logic       next_special_flag, next_pause_flag, next_tx_hold;
  logic       pend_res, pend_pau, next_pend_res, next_pend_pau;
  logic       next_fifo_wr;
  logic [W-1:0] next_fifo_data;
  logic       cts_meta, cts_sync;
  logic       next_rts_n, next_cts_stop, next_sleep_ok;
  uefc_pkg::uefc_txst_t tx_st, next_tx_st;
  logic       sent_pause, next_sent_pause, kind, next_kind;
  logic       next_fc_valid;
  logic [W-1:0] next_fc_data;

  // Decoded controls
  logic       unlocked, efr_access, enh, spec_det;
  logic [1:0] tx_sel, rx_sel;
  logic [3:0] hit;
  logic       res_act, pau_act, pair_rx, either_rx;

  uefc_match_if #(.W(W)) mif ();
  uefc_match #(.W(W)) u_match (.m(mif));
  assign mif.rx_data = rx_data;
  assign mif.chars   = chars;
  assign hit         = mif.hits;

  assign unlocked   = (line_control == uefc_pkg::LCR_UNLOCK);
  assign efr_access = unlocked && !supplementary_feature[uefc_pkg::SFR_LOCK];
  assign enh      = enhanced_feature_control[uefc_pkg::EFR_ENH];
  assign spec_det = enhanced_feature_control[uefc_pkg::EFR_SPEC_DET];
  assign tx_sel   = enhanced_feature_control[3:2];
  assign rx_sel   = enhanced_feature_control[1:0];
  // either-character receive when one transmit pair is chosen
  assign either_rx = (rx_sel == uefc_pkg::FC_BOTH) &&
                     (tx_sel == uefc_pkg::FC_ONE || tx_sel == uefc_pkg::FC_TWO);
  // sequence receive with both pairs or no transmit flow
  assign pair_rx   = (rx_sel == uefc_pkg::FC_BOTH) && !either_rx;

  // ----------------------------------------
  // Receive comparison
  // ----------------------------------------
  // receive compare by lower select bits
  always_comb begin
    res_act = 1'b0;
    pau_act = 1'b0;
    next_pend_res = pend_res;
    next_pend_pau = pend_pau;
    if (rx_valid) begin
      case (rx_sel)
        uefc_pkg::FC_ONE: begin
          res_act = hit[uefc_pkg::CH_RES1];
          pau_act = hit[uefc_pkg::CH_PAU1];
        end
        uefc_pkg::FC_TWO: begin
          res_act = hit[uefc_pkg::CH_RES2];
          pau_act = hit[uefc_pkg::CH_PAU2];
        end
        uefc_pkg::FC_BOTH: begin
          if (either_rx) begin
            // either resume or either pause acts
            res_act = hit[uefc_pkg::CH_RES1] | hit[uefc_pkg::CH_RES2];
            pau_act = hit[uefc_pkg::CH_PAU1] | hit[uefc_pkg::CH_PAU2];
          end else begin
            // only the full pair acts; the first char is still stored
            res_act = pend_res && hit[uefc_pkg::CH_RES2];
            pau_act = pend_pau && hit[uefc_pkg::CH_PAU2];
            next_pend_res = hit[uefc_pkg::CH_RES1];
            next_pend_pau = hit[uefc_pkg::CH_PAU1];
          end
        end
        default: begin
          res_act = 1'b0;
          pau_act = 1'b0;
        end
      endcase
    end
    if (!pair_rx) begin
      next_pend_res = 1'b0;
      next_pend_pau = 1'b0;
    end
  end

  // Push, hold and flag updates; a set in the clearing cycle wins
  always_comb begin
    // consumed flow characters stay out of the FIFO
    next_fifo_wr   = rx_valid && !res_act && !pau_act;
    next_fifo_data = rx_data;
    next_tx_hold = pau_act ? 1'b1 : (res_act ? 1'b0 : tx_hold);
    if (rx_sel == uefc_pkg::FC_NONE) next_tx_hold = 1'b0;
    next_special_flag = special_flag;
    next_pause_flag   = pause_flag;
    if (reg_rd && reg_addr == uefc_pkg::OFS_EFR && !efr_access) begin
      next_special_flag = 1'b0;
      next_pause_flag   = 1'b0;
    end
    // special detect on second pause character
    if (spec_det && rx_valid && hit[uefc_pkg::CH_PAU2]) next_special_flag = 1'b1;
    if (pau_act) next_pause_flag = 1'b1;
  end

  // ----------------------------------------
  // Register writes and reads
  // ----------------------------------------
  always_comb begin
    next_lcr = line_control;
    next_sfr = supplementary_feature;
    next_efr = enhanced_feature_control;
    next_ier = interrupt_enable_reg;
    next_fcr = fifo_control;
    next_mcr = modem_control;
    next_tcr = transmission_control;
    next_tlp = trigger_level_reg;
    next_chars = chars;
    if (reg_wr) begin
      case (reg_addr)
        uefc_pkg::OFS_LCR: next_lcr = reg_wdata;
        uefc_pkg::OFS_SFR: next_sfr = reg_wdata;
        // enhanced bits only change while enhance is set
        uefc_pkg::OFS_IER: next_ier = enh ? reg_wdata :
                                      ((reg_wdata & ~uefc_pkg::IER_ENH_MASK) | (interrupt_enable_reg & uefc_pkg::IER_ENH_MASK));
        uefc_pkg::OFS_EFR: begin
          // access only under the unlock key
          if (efr_access) next_efr = reg_wdata;
          else next_fcr = enh ? reg_wdata :
                          ((reg_wdata & ~uefc_pkg::FCR_ENH_MASK) | (fifo_control & uefc_pkg::FCR_ENH_MASK));
        end
        uefc_pkg::OFS_RES1, uefc_pkg::OFS_RES2, uefc_pkg::OFS_PAU1, uefc_pkg::OFS_PAU2: begin
          if (unlocked) next_chars[reg_addr[1:0]] = reg_wdata[W-1:0];
          else if (reg_addr == uefc_pkg::OFS_MCR)
            next_mcr = enh ? reg_wdata :
                       ((reg_wdata & ~uefc_pkg::MCR_ENH_MASK) | (modem_control & uefc_pkg::MCR_ENH_MASK));
          else if (reg_addr == uefc_pkg::OFS_TCR && enh) next_tcr = reg_wdata;
          else if (reg_addr == uefc_pkg::OFS_TLP && enh) next_tlp = reg_wdata;
        end
        default: next_lcr = line_control;
      endcase
    end
  end

  // Read data is registered one cycle after the strobe
  always_comb begin
    next_reg_rdata = reg_rdata;
    if (reg_rd) begin
      case (reg_addr)
        uefc_pkg::OFS_LCR: next_reg_rdata = line_control;
        uefc_pkg::OFS_SFR: next_reg_rdata = supplementary_feature;
        uefc_pkg::OFS_IER: next_reg_rdata = interrupt_enable_reg;
        uefc_pkg::OFS_EFR: begin
          next_reg_rdata = uefc_pkg::REG_RST;
          if (efr_access) next_reg_rdata = enhanced_feature_control;
          else begin
            next_reg_rdata[uefc_pkg::IIR_SPECIAL] = special_flag;
            next_reg_rdata[uefc_pkg::IIR_PAUSE]   = pause_flag;
            next_reg_rdata[0] = !(special_flag || pause_flag);
          end
        end
        uefc_pkg::OFS_RES1, uefc_pkg::OFS_RES2, uefc_pkg::OFS_PAU1, uefc_pkg::OFS_PAU2: begin
          if (unlocked) next_reg_rdata = 8'(chars[reg_addr[1:0]]);
          else if (reg_addr == uefc_pkg::OFS_MCR) next_reg_rdata = modem_control;
          else if (reg_addr == uefc_pkg::OFS_TCR) next_reg_rdata = transmission_control;
          else if (reg_addr == uefc_pkg::OFS_TLP) next_reg_rdata = trigger_level_reg;
          else next_reg_rdata = uefc_pkg::REG_RST;
        end
        default: next_reg_rdata = uefc_pkg::REG_RST;  // Unmapped reads as zero
      endcase
    end
  end

  // ----------------------------------------
  // Hardware flow control and sleep
  // ----------------------------------------
  always_comb begin
    next_cts_stop = enhanced_feature_control[uefc_pkg::EFR_AUTO_CTS] && cts_sync;
    // automatic request-to-send from FIFO level, else modem_control
    next_rts_n = enhanced_feature_control[uefc_pkg::EFR_AUTO_RTS] ? rx_level_high : !modem_control[uefc_pkg::MCR_RTS];
    // sleep only permitted with enhance set
    next_sleep_ok = enh && interrupt_enable_reg[uefc_pkg::IER_SLEEP];
  end

  // ----------------------------------------
  // Transmit flow character sender
  // ----------------------------------------
  // Resends whenever the sent state lags the FIFO level, so a level that
  // bounces while a character is in flight still settles correctly.
  always_comb begin
    next_tx_st      = tx_st;
    next_kind       = kind;
    next_sent_pause = sent_pause;
    next_fc_valid   = fc_valid;
    next_fc_data    = fc_data;
    case (tx_st)
      uefc_pkg::TX_IDLE: begin
        // upper select bits choose the characters sent
        if (tx_sel != uefc_pkg::FC_NONE && rx_level_high != sent_pause) begin
          next_kind     = rx_level_high;
          next_fc_valid = 1'b1;
          next_tx_st    = uefc_pkg::TX_FIRST;
          if (tx_sel == uefc_pkg::FC_TWO)
            next_fc_data = rx_level_high ? chars[uefc_pkg::CH_PAU2] : chars[uefc_pkg::CH_RES2];
          else
            next_fc_data = rx_level_high ? chars[uefc_pkg::CH_PAU1] : chars[uefc_pkg::CH_RES1];
        end
      end
      uefc_pkg::TX_FIRST: begin
        if (fc_ready) begin
          // both pairs go out as two-character sequences
          if (tx_sel == uefc_pkg::FC_BOTH) begin
            next_fc_data = kind ? chars[uefc_pkg::CH_PAU2] : chars[uefc_pkg::CH_RES2];
            next_tx_st   = uefc_pkg::TX_SECOND;
          end else begin
            next_fc_valid   = 1'b0;
            next_sent_pause = kind;
            next_tx_st      = uefc_pkg::TX_IDLE;
          end
        end
      end
      uefc_pkg::TX_SECOND: begin
        if (fc_ready) begin
          next_fc_valid   = 1'b0;
          next_sent_pause = kind;
          next_tx_st      = uefc_pkg::TX_IDLE;
        end
      end
      default: begin
        next_fc_valid = 1'b0;
        next_tx_st    = uefc_pkg::TX_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      line_control <= uefc_pkg::LCR_RST;
      {supplementary_feature, enhanced_feature_control, interrupt_enable_reg, fifo_control, modem_control, transmission_control, trigger_level_reg, reg_rdata} <= {8{uefc_pkg::REG_RST}};
      for (int i = 0; i < uefc_pkg::CH_NUM; i++) chars[i] <= '0;
      {special_flag, pause_flag, tx_hold, pend_res, pend_pau} <= '0;
      {fifo_wr, cts_meta, cts_sync, cts_stop, sleep_ok, fc_valid, sent_pause, kind} <= '0;
      rts_n     <= 1'b1;
      fifo_data <= '0;
      fc_data   <= '0;
      tx_st     <= uefc_pkg::TX_IDLE;
    end else begin
      {line_control, supplementary_feature, enhanced_feature_control, interrupt_enable_reg} <= {next_lcr, next_sfr, next_efr, next_ier};
      {fifo_control, modem_control, transmission_control, trigger_level_reg} <= {next_fcr, next_mcr, next_tcr, next_tlp};
      chars        <= next_chars;
      reg_rdata    <= next_reg_rdata;
      special_flag <= next_special_flag;
      pause_flag   <= next_pause_flag;
      tx_hold      <= next_tx_hold;
      pend_res     <= next_pend_res;
      pend_pau     <= next_pend_pau;
      fifo_wr      <= next_fifo_wr;
      fifo_data    <= next_fifo_data;
      cts_meta     <= cts_n;     // Pin synchroniser, first stage
      cts_sync     <= cts_meta;
      cts_stop     <= next_cts_stop;
      rts_n        <= next_rts_n;
      sleep_ok     <= next_sleep_ok;
      tx_st        <= next_tx_st;
      kind         <= next_kind;
      sent_pause   <= next_sent_pause;
      fc_valid     <= next_fc_valid;
      fc_data      <= next_fc_data;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  efr_locked_a: assert property (reg_wr && reg_addr == uefc_pkg::OFS_EFR && !efr_access
                                 |=> $stable(enhanced_feature_control)) else $error("feature register written while locked");
  cts_follow_a: assert property (enhanced_feature_control[uefc_pkg::EFR_AUTO_CTS] && $past(cts_n, 2) && $stable(enhanced_feature_control)
                                 |=> cts_stop) else $error("clear-to-send stop missing");
  rts_auto_a: assert property (enhanced_feature_control[uefc_pkg::EFR_AUTO_RTS] |=> rts_n == $past(rx_level_high))
                               else $error("request-to-send not following level");
  spec_flag_a: assert property (spec_det && rx_valid && hit[uefc_pkg::CH_PAU2]
                                |=> special_flag) else $error("special character flag not raised");
  pause_skip_a: assert property (pau_act |=> !fifo_wr && pause_flag && tx_hold)
                                else $error("pause character reached the FIFO");
  fcr_gate_a: assert property (reg_wr && reg_addr == uefc_pkg::OFS_EFR && !efr_access && !enh
                               |=> (fifo_control & uefc_pkg::FCR_ENH_MASK) == $past(fifo_control & uefc_pkg::FCR_ENH_MASK))
                               else $error("enhanced fifo bits changed while gated");
  sleep_gate_a: assert property (!enh |=> !sleep_ok) else $error("sleep permitted without enhance");
  tx_none_a: assert property (tx_st == uefc_pkg::TX_IDLE && tx_sel == uefc_pkg::FC_NONE
                              |=> !fc_valid) else $error("flow character sent with transmit flow off");
  pair_send_a: assert property (tx_st == uefc_pkg::TX_FIRST && fc_ready && tx_sel == uefc_pkg::FC_BOTH
                                |=> fc_valid && fc_data == (kind ? chars[uefc_pkg::CH_PAU2] : chars[uefc_pkg::CH_RES2]))
                                else $error("second character of pair missing");
  resume_a: assert property (res_act |=> !tx_hold ##1 1'b1) else $error("resume did not release");

  pause_seen_c: cover property (pau_act ##[1:20] res_act);
  pair_tx_c: cover property (tx_st == uefc_pkg::TX_FIRST ##1 tx_st == uefc_pkg::TX_SECOND);
  spec_store_c: cover property (spec_det && rx_valid && hit[uefc_pkg::CH_PAU2] && next_fifo_wr);
endmodule
`default_nettype wire

// [verif/uefc_remote.sv]
`default_nettype none
// ----------------------------------------
// Remote transmitter taking flow characters
// ----------------------------------------
module uefc_remote (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // Flow character handshake
  input  wire logic       fc_valid,
  input  wire logic [7:0] fc_data,
  output logic            fc_ready,
  // Bench control and status
  input  wire logic       slow,
  output logic            hold_err
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] gap;
  logic [7:0] held;
  logic       pend;
  // offered character held
  // Slow mode takes one character in four cycles, so a character must stand while stalled
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gap      <= 2'h0;
      fc_ready <= 1'b0;
      held     <= 8'h00;
      pend     <= 1'b0;
      hold_err <= 1'b0;
    end else begin
      gap      <= gap + 2'h1;
      fc_ready <= !slow || (gap == 2'h2);
      pend     <= fc_valid && !fc_ready;
      held     <= fc_data;
      if (pend && fc_valid && (fc_data != held)) begin
        hold_err <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// [verif/uart_enhanced_flow_control_tb.sv]
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module uart_enhanced_flow_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rx_valid = 1'b0;
  logic       rx_level_high = 1'b0, cts_n = 1'b0, slow = 1'b0, rd_pend = 1'b0, hold_e;
  logic       fc_ready, hold_err, fifo_wr, fc_valid, rts_n, cts_stop, tx_hold;
  logic       special_flag, pause_flag, sleep_ok;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, rx_data = 8'h00, reg_rdata, fifo_data, fc_data, seen;
  logic [8:0] exp_q[$];
  logic [8:0] e;
  logic [7:0] chv[4] = '{8'h11, 8'h13, 8'h19, 8'h17};
  int         mismatches = 0, check_count = 0, cycles = 0;
  int         ord[4] = '{2, 0, 3, 1};
  logic [3:0] modes[4] = '{4'h2, 4'h1, 4'hb, 4'h7};

  uefc_top #(.W(8)) dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rx_valid(rx_valid), .rx_data(rx_data),
    .fifo_wr(fifo_wr), .fifo_data(fifo_data), .rx_level_high(rx_level_high), .fc_valid(fc_valid),
    .fc_data(fc_data), .fc_ready(fc_ready), .cts_n(cts_n), .rts_n(rts_n), .cts_stop(cts_stop),
    .tx_hold(tx_hold), .special_flag(special_flag), .pause_flag(pause_flag), .sleep_ok(sleep_ok));
  uefc_remote remote (.clk(clk), .nrst(nrst), .fc_valid(fc_valid), .fc_data(fc_data),
    .fc_ready(fc_ready), .slow(slow), .hold_err(hold_err));

  always #2 clk = ~clk;

  // ----------------------------------------
  // Result monitor
  // ----------------------------------------
  // Reads, FIFO pushes and sent flow characters each take the oldest note; bit 8 marks don't care
  always @(posedge clk) begin
    if (rd_pend || fifo_wr || (fc_valid && fc_ready)) begin
      seen = rd_pend ? reg_rdata : (fifo_wr ? fifo_data : fc_data);
      if (exp_q.size() == 0) begin
        mismatches++;
        $display("CHECK FAILED result expected none seen %h", seen);
      end else begin
        e = exp_q.pop_front();
        if (!e[8]) `CHK("result", e[7:0], seen)
      end
    end
    rd_pend = reg_rd;
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      print_verdict();
    end
  end

  // ----------------------------------------
  // Drivers, all launched at the falling edge
  // ----------------------------------------
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(negedge clk);
    reg_addr  = a;
    reg_wdata = v;
    reg_wr    = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [8:0] x);
    exp_q.push_back(x);
    @(negedge clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
  endtask

  // Waits afterwards so level outputs have settled before they are looked at
  task automatic rx(input logic [7:0] v, input bit kept);
    if (kept) exp_q.push_back({1'b0, v});
    @(negedge clk);
    rx_data  = v;
    rx_valid = 1'b1;
    @(negedge clk);
    rx_valid = 1'b0;
    repeat (2) @(negedge clk);
  endtask

  task automatic set_efr(input logic [7:0] v);
    wr(uefc_pkg::OFS_LCR, uefc_pkg::LCR_UNLOCK);
    wr(uefc_pkg::OFS_EFR, v);
    wr(uefc_pkg::OFS_LCR, 8'h03);
  endtask

  // Whether a single-character receive mode consumes character slot i
  function automatic bit acts(input logic [3:0] s, input int i);
    case (s[1:0])
      uefc_pkg::FC_ONE:  return (i == 0) || (i == 2);
      uefc_pkg::FC_TWO:  return (i == 1) || (i == 3);
      uefc_pkg::FC_BOTH: return 1'b1;
      default:           return 1'b0;
    endcase
  endfunction

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(73744));
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    // Feature register lock, reset value and field placement
    wr(uefc_pkg::OFS_LCR, uefc_pkg::LCR_UNLOCK);
    rd(uefc_pkg::OFS_EFR, 9'h000);
    wr(uefc_pkg::OFS_SFR, 8'h04);
    wr(uefc_pkg::OFS_EFR, 8'hff);
    wr(uefc_pkg::OFS_SFR, 8'h00);
    rd(uefc_pkg::OFS_EFR, 9'h000);
    wr(uefc_pkg::OFS_EFR, 8'h10);
    rd(uefc_pkg::OFS_EFR, 9'h010);
    for (int i = 0; i < 4; i++) wr(uefc_pkg::OFS_RES1 + 4'(i), chv[i]);
    wr(uefc_pkg::OFS_LCR, 8'h03);
    $display("test lock done");
    // Enhance bit gates enhanced interrupt enable bits and sleep
    set_efr(8'h00);
    wr(uefc_pkg::OFS_IER, 8'h10);
    set_efr(8'h10);
    `CHK("sleep_ok", 1'b0, sleep_ok)
    wr(uefc_pkg::OFS_IER, 8'h10);
    repeat (2) @(negedge clk);
    `CHK("sleep_ok", 1'b1, sleep_ok)
    set_efr(8'h00);
    `CHK("sleep_ok", 1'b0, sleep_ok)
    $display("test enhance done");
    // Automatic request-to-send and clear-to-send
    wr(uefc_pkg::OFS_MCR, 8'h02);
    rx_level_high = 1'b1;
    repeat (3) @(negedge clk);
    `CHK("rts_n", 1'b0, rts_n)
    set_efr(8'h40);
    `CHK("rts_n", 1'b1, rts_n)
    rx_level_high = 1'b0;
    cts_n = 1'b1;
    repeat (5) @(negedge clk);
    `CHK("rts_n", 1'b0, rts_n)
    `CHK("cts_stop", 1'b0, cts_stop)
    set_efr(8'hc0);
    repeat (3) @(negedge clk);
    `CHK("cts_stop", 1'b1, cts_stop)
    cts_n = 1'b0;
    repeat (5) @(negedge clk);
    `CHK("cts_stop", 1'b0, cts_stop)
    $display("test modem done");
    // Single-character receive modes, then an unrelated random character
    foreach (modes[m]) begin
      set_efr(8'h00);
      set_efr({4'h0, modes[m]});
      hold_e = 1'b0;
      foreach (ord[k]) begin
        rx(chv[ord[k]], !acts(modes[m], ord[k]));
        if (acts(modes[m], ord[k])) hold_e = (ord[k] >= 2);
        `CHK("tx_hold", hold_e, tx_hold)
      end
      rx({2'b01, 6'($urandom)}, 1'b1);
    end
    $display("test receive done");
    // Two-character sequence modes
    for (int m = 0; m < 2; m++) begin
      set_efr(8'h00);
      set_efr(m ? 8'h0f : 8'h03);
      rx(chv[3], 1'b1);
      rx(chv[2], 1'b1);
      rx(chv[3], 1'b0);
      `CHK("tx_hold", 1'b1, tx_hold)
      rx(chv[0], 1'b1);
      rx(chv[1], 1'b0);
      `CHK("tx_hold", 1'b0, tx_hold)
    end
    $display("test sequence done");
    // Special character detection, stored and consumed
    set_efr(8'h00);
    rd(uefc_pkg::OFS_EFR, 9'h100);
    set_efr(8'h22);
    rx(chv[3], 1'b1);
    `CHK("special_flag", 1'b1, special_flag)
    rd(uefc_pkg::OFS_EFR, 9'h010);
    set_efr(8'h00);
    set_efr(8'h21);
    rx(chv[3], 1'b0);
    `CHK("tx_hold", 1'b1, tx_hold)
    rd(uefc_pkg::OFS_EFR, 9'h030);
    $display("test special done");
    // Transmit modes, partner stalling on odd passes
    for (int h = 1; h < 4; h++) begin
      set_efr({4'h0, 2'(h), 2'b00});
      slow = h[0];
      if (h[1]) exp_q.push_back({1'b0, chv[2]});
      if (h[0]) exp_q.push_back({1'b0, chv[3]});
      rx_level_high = 1'b1;
      repeat (25) @(negedge clk);
      if (h[1]) exp_q.push_back({1'b0, chv[0]});
      if (h[0]) exp_q.push_back({1'b0, chv[1]});
      rx_level_high = 1'b0;
      repeat (25) @(negedge clk);
    end
    `CHK("hold_err", 1'b0, hold_err)
    `CHK("pending", 0, exp_q.size())
    $display("test transmit done");
    print_verdict();
  end
endmodule
`default_nettype wire
